// ### logic/nvmac_pkg.sv
`default_nettype none
package nvmac_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_DATA_LOW   = 8'h00;
	localparam logic [7:0] OFS_DATA_HIGH  = 8'h04;
	localparam logic [7:0] OFS_ADDR_LOW   = 8'h08;
	localparam logic [7:0] OFS_ADDR_HIGH  = 8'h0c;
	localparam logic [7:0] OFS_CONTROL    = 8'h10;
	localparam logic [7:0] OFS_UNLOCK_KEY = 8'h14;
	localparam logic [7:0] OFS_STATUS     = 8'h18;
	// control register field positions
	localparam int CTL_FLASH  = 7;
	localparam int CTL_CONFIG = 6;
	localparam int CTL_LATCH  = 5;
	localparam int CTL_ERASE  = 4;
	localparam int CTL_FAULT  = 3;
	localparam int CTL_ALLOW  = 2;
	localparam int CTL_WR     = 1;
	localparam int CTL_RD     = 0;
	// status register field positions
	localparam int STS_DONE   = 0;
	localparam int STS_BUSY   = 1;
	localparam int STS_STALL  = 2;
	// unlock pattern
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	// memory geometry
	localparam int ADDR_W      = 15;
	localparam int WORD_W      = 14;
	localparam int LATCH_WORDS = 8;
	localparam int EE_DEPTH    = 256;
	localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3fff;
	// configuration space word indices
	localparam logic [ADDR_W-1:0] CFG_USER_LAST = 15'h0003;
	localparam logic [ADDR_W-1:0] CFG_DEV_ID    = 15'h0006;
	localparam logic [ADDR_W-1:0] CFG_WORD_1    = 15'h0007;
	localparam logic [ADDR_W-1:0] CFG_WORD_2    = 15'h0008;
	// identity and configuration contents, values are arbitrary
	localparam logic [WORD_W-1:0] DEV_ID_VALUE = 14'h1234;
	localparam logic [WORD_W-1:0] CFG_1_VALUE  = 14'h0abc;
	localparam logic [WORD_W-1:0] CFG_2_VALUE  = 14'h0def;
	// self-timed operation length
	localparam int CLK_NS     = 20;
	localparam int OP_TIME_NS = 4000;
	localparam int OP_CYCLES  = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W      = 8;
	// sequencer states
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_LATCH = 3'b010,
		ST_TIMED = 3'b100
	} nvmac_state_t;
endpackage : nvmac_pkg
`default_nettype wire

// ### logic/nvmac_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface nvmac_mem_if;
	import nvmac_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [WORD_W-1:0] wdata;
	logic [WORD_W-1:0] rdata;
	logic              flash_sel;
	logic              cfg_sel;
	logic              latch_we;
	logic              ee_write;
	logic              row_erase;
	logic              row_prog;
	modport ctrl (output addr, wdata, flash_sel, cfg_sel, latch_we, ee_write, row_erase, row_prog, input rdata);
	modport store (input addr, wdata, flash_sel, cfg_sel, latch_we, ee_write, row_erase, row_prog, output rdata);
endinterface : nvmac_mem_if
`default_nettype wire

// ### logic/nvmac_timer.sv
`timescale 1ns/100ps
`default_nettype none
module nvmac_timer
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// control
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	import nvmac_pkg::*;
	logic [TMR_W-1:0] cnt_q;

	// down counter, loaded on start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (ce)
		begin
			if (start)
				cnt_q <= OP_CYCLES[TMR_W-1:0];
			else if (cnt_q != '0)
				cnt_q <= cnt_q - 8'h01;
		end
	end

	// done on the last counted cycle
	assign busy = (cnt_q != '0);
	assign done = (cnt_q == 8'h01);
endmodule : nvmac_timer
`default_nettype wire

// ### logic/nvmac_store.sv
`timescale 1ns/100ps
`default_nettype none
module nvmac_store
(
	// clock
	input  wire logic pclk,
	input  wire logic ce,
	// array port
	nvmac_mem_if.store mem
);
	import nvmac_pkg::*;
	logic [WORD_W-1:0] flash_mem [0:(1<<ADDR_W)-1];
	logic [7:0]        ee_mem    [0:EE_DEPTH-1];
	logic [WORD_W-1:0] user_id   [0:3];
	logic [WORD_W-1:0] latch_mem [0:LATCH_WORDS-1];
	logic [ADDR_W-4:0] row;
	logic              cfg_ok;

	assign row = mem.addr[ADDR_W-1:3];

	// only user ids, device id and config words answer in config space
	assign cfg_ok = (mem.addr <= CFG_USER_LAST) || (mem.addr == CFG_DEV_ID) ||
		(mem.addr == CFG_WORD_1) || (mem.addr == CFG_WORD_2);

	// arrays carry no reset, as real cells would not
	always_ff @(posedge pclk)
	begin
		if (ce)
		begin
			if (mem.latch_we)
				latch_mem[mem.addr[2:0]] <= mem.wdata;
			if (mem.ee_write)
				ee_mem[mem.addr[7:0]] <= mem.wdata[7:0];
			for (int i = 0; i < LATCH_WORDS; i++)
			begin
				if (mem.cfg_sel && i < 4)
				begin
					if (mem.row_erase)
						user_id[i] <= ERASED_WORD;
					else if (mem.row_prog)
						user_id[i] <= latch_mem[i];
				end
				else if (!mem.cfg_sel)
				begin
					if (mem.row_erase)
						flash_mem[{row, 3'(i)}] <= ERASED_WORD;
					else if (mem.row_prog)
						flash_mem[{row, 3'(i)}] <= latch_mem[i];
				end
			end
		end
	end

	// read port, zero for config locations outside the table
	always_comb
	begin
		if (mem.cfg_sel)
		begin
			if (!cfg_ok)
				mem.rdata = '0;
			else if (mem.addr <= CFG_USER_LAST)
				mem.rdata = user_id[mem.addr[1:0]];
			else if (mem.addr == CFG_DEV_ID)
				mem.rdata = DEV_ID_VALUE;
			else if (mem.addr == CFG_WORD_1)
				mem.rdata = CFG_1_VALUE;
			else
				mem.rdata = CFG_2_VALUE;
		end
		else if (mem.flash_sel)
			mem.rdata = flash_mem[mem.addr];
		else
			mem.rdata = {6'h00, ee_mem[mem.addr[7:0]]};
	end
endmodule : nvmac_store
`default_nettype wire

// ### logic/nvmac_top.sv
// How it works
// - data low holds an eeprom byte or low eight program word bits
// - data high holds word bits 13..8; bits 7..6 read zero
// - address low is eight bits, zero after reset
// - address high holds seven bits, zero after reset, top bit reads zero
// - control bit 7 picks program flash, else data eeprom
// - control bit 6 redirects to config, user id and device id words
// - latch-only set: write only loads the latch, no programming
// - latch-only clear: load latch, then program all latched words
// - eeprom target ignores latch-only; every write starts an eeprom write
// - erase select makes the write an erase; hardware clears it after
// - eeprom target ignores erase select; does erase then write
// - fault flag set on every write start attempt, cleared by normal completion
// - program allow clear blocks every program and erase
// - write start runs a timed operation except a latch-only load, hardware clears it, zero ignored
// - read start loads data registers in one cycle, then self clears
// - key register has no storage, only watched for the pattern
// - config ids 0-3 read/write, device id and config words read only
// - config read outside the allowed set returns zero
// - cpu stalls during program flash operations until done
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module nvmac_top
(
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// core side
	output logic             cpu_stall,
	output logic             nv_done_flag
);
	import nvmac_pkg::*;

	nvmac_mem_if mem ();

	logic [31:0]       prdata_q;
	logic              pready_q;
	logic              pslverr_q;
	logic [7:0]        data_low_q;
	logic [5:0]        data_high_q;
	logic [7:0]        addr_low_q;
	logic [6:0]        addr_high_q;
	logic              flash_sel_q;
	logic              cfg_sel_q;
	logic              latch_only_q;
	logic              erase_sel_q;
	logic              fault_q;
	logic              allow_q;
	logic              wr_q;
	logic              rd_q;
	logic              key_half_q;
	logic              unlocked_q;
	logic              done_q;
	logic              stall_q;
	nvmac_state_t      st_q;
	logic              op_ee_q;
	logic              op_erase_q;
	logic              op_latch_q;
	logic              op_cfg_q;
	logic [ADDR_W-1:0] op_addr_q;
	logic [WORD_W-1:0] op_data_q;
	logic [ADDR_W-1:0] cur_addr;
	logic              take;
	logic              wr_hit;
	logic              wr_ctl;
	logic              wr_key;
	logic              mapped;
	logic [7:0]        rd_mux;
	logic [7:0]        ctl_rd;
	logic              wr_attempt;
	logic              target_ee;
	logic              legal;
	logic              go;
	logic              tmr_start;
	logic              tmr_done;
	logic              finish;

	// apb answer: pready one cycle into the access phase
	assign take    = psel && penable && pready_q && ce;
	assign wr_hit  = take && pwrite && pstrb[0];
	assign wr_ctl  = wr_hit && (paddr == OFS_CONTROL);
	assign wr_key  = wr_hit && (paddr == OFS_UNLOCK_KEY);
	assign cur_addr = {addr_high_q, addr_low_q};
	assign ctl_rd  = {flash_sel_q, cfg_sel_q, latch_only_q, erase_sel_q, fault_q, allow_q, wr_q, rd_q};

	// register read mux
	always_comb
	begin
		mapped = 1'b1;
		if (paddr == OFS_DATA_LOW)
			rd_mux = data_low_q;
		else if (paddr == OFS_DATA_HIGH)
			rd_mux = {2'b00, data_high_q};
		else if (paddr == OFS_ADDR_LOW)
			rd_mux = addr_low_q;
		else if (paddr == OFS_ADDR_HIGH)
			rd_mux = {1'b0, addr_high_q};
		else if (paddr == OFS_CONTROL)
			rd_mux = ctl_rd;
		else if (paddr == OFS_UNLOCK_KEY)
			rd_mux = 8'h00;
		else if (paddr == OFS_STATUS)
			rd_mux = {5'h00, stall_q, wr_q, done_q};
		else
		begin
			rd_mux = 8'h00;
			mapped = 1'b0;
		end
	end

	// bus handshake and read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end
		else if (ce)
		begin
			pready_q <= psel && penable && !pready_q;
			if (psel && penable && !pready_q)
			begin
				prdata_q  <= pwrite ? 32'h00000000 : {24'h000000, rd_mux};
				pslverr_q <= !mapped;
			end
			else
				pslverr_q <= 1'b0;
		end
	end

	a_ready_pulse : assert property (@(posedge pclk) disable iff (!presetn || !ce)
		pready_q |=> !pready_q) else $error("pready held longer than one cycle");

	// write start checks; config writes only reach user ids
	assign wr_attempt = wr_ctl && pwdata[CTL_WR] && !wr_q;
	assign target_ee  = !flash_sel_q && !cfg_sel_q;
	assign legal      = !cfg_sel_q || (cur_addr <= CFG_USER_LAST);
	assign go         = wr_attempt && unlocked_q && allow_q && legal && st_q == ST_IDLE;

	// unlock pattern watcher, any other write breaks the sequence
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_half_q <= 1'b0;
			unlocked_q <= 1'b0;
		end
		else if (ce && wr_hit)
		begin
			if (wr_key && pwdata[7:0] == KEY_FIRST)
			begin
				key_half_q <= 1'b1;
				unlocked_q <= 1'b0;
			end
			else if (wr_key && pwdata[7:0] == KEY_SECOND && key_half_q)
			begin
				key_half_q <= 1'b0;
				unlocked_q <= 1'b1;
			end
			else
			begin
				key_half_q <= 1'b0;
				unlocked_q <= 1'b0;
			end
		end
	end

	a_wr_unlocked : assert property (@(posedge pclk) disable iff (!presetn || !ce)
		$rose(wr_q) |-> $past(unlocked_q) && $past(allow_q)) else $error("write started without unlock");

	// data registers: software writes, read start loads them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			data_low_q  <= 8'h00;
			data_high_q <= 6'h00;
		end
		else if (ce)
		begin
			if (rd_q)
			begin
				data_low_q  <= mem.rdata[7:0];
				data_high_q <= mem.rdata[13:8];
			end
			else if (wr_hit && paddr == OFS_DATA_LOW)
				data_low_q <= pwdata[7:0];
			else if (wr_hit && paddr == OFS_DATA_HIGH)
				data_high_q <= pwdata[5:0];
		end
	end

	a_rd_load : assert property (@(posedge pclk) disable iff (!presetn || !ce)
		rd_q |=> !rd_q && data_low_q == $past(mem.rdata[7:0]) && data_high_q == $past(mem.rdata[13:8]))
		else $error("read start did not load data in one cycle");

	// address registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_low_q  <= 8'h00;
			addr_high_q <= 7'h00;
		end
		else if (ce)
		begin
			if (wr_hit && paddr == OFS_ADDR_LOW)
				addr_low_q <= pwdata[7:0];
			else if (wr_hit && paddr == OFS_ADDR_HIGH)
				addr_high_q <= pwdata[6:0];
		end
	end

	// space and mode bits, erase select cleared when an erase ends
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flash_sel_q  <= 1'b0;
			cfg_sel_q    <= 1'b0;
			latch_only_q <= 1'b0;
			erase_sel_q  <= 1'b0;
			allow_q      <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_ctl)
			begin
				flash_sel_q  <= pwdata[CTL_FLASH];
				cfg_sel_q    <= pwdata[CTL_CONFIG];
				latch_only_q <= pwdata[CTL_LATCH];
				allow_q      <= pwdata[CTL_ALLOW];
			end
			if (finish && op_erase_q)
				erase_sel_q <= 1'b0;
			else if (wr_ctl)
				erase_sel_q <= pwdata[CTL_ERASE];
		end
	end

	// start, read and fault bits: software can only set the start bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
			fault_q <= 1'b0;
		end
		else if (ce)
		begin
			if (go)
				wr_q <= 1'b1;
			else if (finish || st_q == ST_LATCH && op_latch_q)
				wr_q <= 1'b0;
			if (rd_q)
				rd_q <= 1'b0;
			else if (wr_ctl && pwdata[CTL_RD] && st_q == ST_IDLE)
				rd_q <= 1'b1;
			// an attempt wins over a completion in the same cycle
			if (wr_attempt)
				fault_q <= 1'b1;
			else if (finish || st_q == ST_LATCH && op_latch_q)
				fault_q <= 1'b0;
			else if (wr_ctl)
				fault_q <= pwdata[CTL_FAULT];
		end
	end

	a_fault_set : assert property (@(posedge pclk) disable iff (!presetn || !ce)
		wr_attempt && !go |=> fault_q && !wr_q) else $error("refused write left no fault");

	a_blocked : assert property (@(posedge pclk) disable iff (!presetn || !ce)
		st_q == ST_IDLE && !allow_q |=> st_q == ST_IDLE) else $error("operation began while not allowed");

	// sequencer: latch load, then optional timed cycle; eeprom writes and erases go straight to the timed cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q       <= ST_IDLE;
			op_ee_q    <= 1'b0;
			op_erase_q <= 1'b0;
			op_latch_q <= 1'b0;
			op_cfg_q   <= 1'b0;
			op_addr_q  <= 15'h0000;
			op_data_q  <= 14'h0000;
		end
		else if (ce)
		begin
			case (st_q)
				ST_IDLE:
				begin
					if (go)
					begin
						op_ee_q    <= target_ee;
						op_erase_q <= !target_ee && erase_sel_q;
						op_latch_q <= !target_ee && !erase_sel_q && latch_only_q;
						op_cfg_q   <= cfg_sel_q;
						op_addr_q  <= cur_addr;
						op_data_q  <= {data_high_q, data_low_q};
						if (target_ee || erase_sel_q)
							st_q <= ST_TIMED;
						else
							st_q <= ST_LATCH;
					end
				end
				ST_LATCH:
				begin
					if (op_latch_q)
						st_q <= ST_IDLE;
					else
						st_q <= ST_TIMED;
				end
				ST_TIMED:
				begin
					if (tmr_done)
						st_q <= ST_IDLE;
				end
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	a_ee_direct : assert property (@(posedge pclk) disable iff (!presetn || !ce)
		go && target_ee |=> st_q == ST_TIMED && op_ee_q) else $error("eeprom write did not start directly");

	a_latch_only : assert property (@(posedge pclk) disable iff (!presetn || !ce)
		go && !target_ee && !erase_sel_q && latch_only_q |=> st_q == ST_LATCH ##1 st_q == ST_IDLE && !wr_q)
		else $error("latch-only write ran a programming cycle");

	// timer and memory strobes
	assign tmr_start = (go && (target_ee || erase_sel_q)) || (st_q == ST_LATCH && !op_latch_q);
	assign finish    = (st_q == ST_TIMED) && tmr_done;

	nvmac_timer u_timer
	(
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.start   (tmr_start),
		.busy    (),
		.done    (tmr_done)
	);

	assign mem.addr      = (st_q == ST_IDLE) ? cur_addr : op_addr_q;
	assign mem.wdata     = op_data_q;
	assign mem.flash_sel = (st_q == ST_IDLE) ? flash_sel_q : !op_ee_q;
	assign mem.cfg_sel   = (st_q == ST_IDLE) ? cfg_sel_q : op_cfg_q;
	assign mem.latch_we  = (st_q == ST_LATCH);
	assign mem.ee_write  = finish && op_ee_q;
	assign mem.row_erase = finish && op_erase_q;
	assign mem.row_prog  = finish && !op_ee_q && !op_erase_q;

	nvmac_store u_store
	(
		.pclk (pclk),
		.ce   (ce),
		.mem  (mem)
	);

	// done flag: hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			done_q <= 1'b0;
		else if (ce)
		begin
			if (finish)
				done_q <= 1'b1;
			else if (wr_hit && paddr == OFS_STATUS && pwdata[STS_DONE])
				done_q <= 1'b0;
		end
	end

	a_done_set : assert property (@(posedge pclk) disable iff (!presetn || !ce)
		finish |=> done_q && !wr_q && !fault_q) else $error("completion did not signal done");

	// core stall for program and config operations only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stall_q <= 1'b0;
		else if (ce)
		begin
			if (go && !target_ee)
				stall_q <= 1'b1;
			else if (finish || st_q == ST_LATCH && op_latch_q)
				stall_q <= 1'b0;
		end
	end

	a_stall_flash : assert property (@(posedge pclk) disable iff (!presetn || !ce)
		st_q == ST_TIMED && !op_ee_q |-> stall_q) else $error("core not stalled during flash cycle");

	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign cpu_stall    = stall_q;
	assign nv_done_flag = done_q;
endmodule : nvmac_top
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import nvmac_pkg::*;
	// clock, reset and bus drive
	logic        pclk;
	logic        presetn;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	// design answers
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cpu_stall;
	logic        nv_done_flag;
	// bookkeeping
	logic [31:0] last_rdata;
	logic        last_err;
	int          fail_count;
	int          n_checks;
	int          cycles;

	nvmac_top i_dut
	(
		.pclk         (pclk),
		.presetn      (presetn),
		.ce           (ce),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.pstrb        (pstrb),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.cpu_stall    (cpu_stall),
		.nv_done_flag (nv_done_flag)
	);

	// 50 mhz clock
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// hang guard, far above the roughly 1450 cycles the run needs
	always @(posedge pclk)
	begin
		cycles = cycles + 1;
		if (cycles == 30000)
		begin
			fail_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// one apb transfer; waits for pready rather than assuming the wait state
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		last_rdata = prdata;
		last_err   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, last_rdata, exp);
	endtask : rd_chk

	// key pair must be the two writes right before the start
	task automatic unlock(input logic [7:0] ctl);
		apb(1'b1, OFS_UNLOCK_KEY, {24'h0, KEY_FIRST});
		apb(1'b1, OFS_UNLOCK_KEY, {24'h0, KEY_SECOND});
		apb(1'b1, OFS_CONTROL, {24'h0, ctl});
	endtask : unlock

	// poll the start bit; the guard counter ends a hang
	task automatic wait_idle();
		do apb(1'b0, OFS_CONTROL, 32'h0); while (last_rdata[CTL_WR] !== 1'b0);
	endtask : wait_idle

	task automatic set_addr(input logic [14:0] a);
		apb(1'b1, OFS_ADDR_LOW, {24'h0, a[7:0]});
		apb(1'b1, OFS_ADDR_HIGH, {25'h0, a[14:8]});
	endtask : set_addr

	task automatic t_reset();
		rd_chk(OFS_ADDR_LOW, 32'h0, "addr_low reset");
		rd_chk(OFS_ADDR_HIGH, 32'h0, "addr_high reset");
		rd_chk(OFS_CONTROL, 32'h0, "control reset");
		chk("done reset", {31'h0, nv_done_flag}, 32'h0);
		chk("stall reset", {31'h0, cpu_stall}, 32'h0);
	endtask : t_reset

	// a write without the low byte strobe must leave the register alone
	task automatic t_gate();
		pstrb <= 4'he;
		apb(1'b1, OFS_ADDR_LOW, 32'h0000_0011);
		pstrb <= 4'hf;
		rd_chk(OFS_ADDR_LOW, 32'h0000_0020, "strobe off ignored");
	endtask : t_gate

	task automatic t_regs();
		apb(1'b1, OFS_DATA_LOW, 32'hffff_ffa5);
		rd_chk(OFS_DATA_LOW, 32'h0000_00a5, "data_low");
		apb(1'b1, OFS_DATA_HIGH, 32'h0000_00ff);
		rd_chk(OFS_DATA_HIGH, 32'h0000_003f, "data_high");
		apb(1'b1, OFS_ADDR_LOW, 32'h0000_005a);
		rd_chk(OFS_ADDR_LOW, 32'h0000_005a, "addr_low");
		apb(1'b1, OFS_ADDR_HIGH, 32'h0000_00ff);
		rd_chk(OFS_ADDR_HIGH, 32'h0000_007f, "addr_high");
		apb(1'b1, OFS_UNLOCK_KEY, {24'h0, KEY_FIRST});
		rd_chk(OFS_UNLOCK_KEY, 32'h0, "key reads zero");
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped error", {31'h0, last_err}, 32'h1);
	endtask : t_regs

	// refused starts: no allow, then allow without keys
	task automatic t_locked();
		set_addr(15'h0020);
		apb(1'b1, OFS_CONTROL, 32'h0);
		unlock(8'h02);
		rd_chk(OFS_CONTROL, 32'h0000_0008, "start without allow");
		apb(1'b1, OFS_CONTROL, 32'h0000_0004);
		apb(1'b1, OFS_CONTROL, 32'h0000_0006);
		rd_chk(OFS_CONTROL, 32'h0000_000c, "start without key");
		chk("no done when refused", {31'h0, nv_done_flag}, 32'h0);
	endtask : t_locked

	// eeprom write, done flag, w1c clear and read back
	task automatic ee_round(input logic [7:0] d, input logic [7:0] ctl);
		apb(1'b1, OFS_DATA_LOW, {24'h0, d});
		apb(1'b1, OFS_CONTROL, {24'h0, ctl});
		unlock(ctl | 8'h02);
		apb(1'b1, OFS_CONTROL, {24'h0, ctl});
		rd_chk(OFS_CONTROL, {24'h0, ctl | 8'h02}, "zero write ignored");
		wait_idle();
		chk("fault cleared", {31'h0, last_rdata[CTL_FAULT]}, 32'h0);
		chk("done set", {31'h0, nv_done_flag}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h1);
		chk("done cleared", {31'h0, nv_done_flag}, 32'h0);
		apb(1'b1, OFS_DATA_LOW, 32'h0);
		apb(1'b1, OFS_CONTROL, {24'h0, ctl | 8'h01});
		rd_chk(OFS_DATA_LOW, {24'h0, d}, "eeprom read back");
		rd_chk(OFS_CONTROL, {24'h0, ctl}, "read bit clears");
	endtask : ee_round

	task automatic t_config();
		set_addr(CFG_DEV_ID);
		apb(1'b1, OFS_CONTROL, 32'h0000_0041);
		rd_chk(OFS_DATA_LOW, {24'h0, DEV_ID_VALUE[7:0]}, "device id low");
		rd_chk(OFS_DATA_HIGH, {26'h0, DEV_ID_VALUE[13:8]}, "device id high");
		set_addr(15'h0005);
		apb(1'b1, OFS_CONTROL, 32'h0000_0041);
		rd_chk(OFS_DATA_LOW, 32'h0, "hole low");
		rd_chk(OFS_DATA_HIGH, 32'h0, "hole high");
		set_addr(CFG_WORD_1);
		apb(1'b1, OFS_CONTROL, 32'h0000_0044);
		unlock(8'h46);
		rd_chk(OFS_CONTROL, 32'h0000_004c, "config word write refused");
		set_addr(15'h0002);
		apb(1'b1, OFS_DATA_LOW, 32'h0000_005e);
		apb(1'b1, OFS_DATA_HIGH, 32'h0000_0003);
		apb(1'b1, OFS_CONTROL, 32'h0000_0044);
		unlock(8'h46);
		wait_idle();
		chk("user id done", {31'h0, nv_done_flag}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h1);
		apb(1'b1, OFS_DATA_LOW, 32'h0);
		apb(1'b1, OFS_DATA_HIGH, 32'h0);
		apb(1'b1, OFS_CONTROL, 32'h0000_0041);
		rd_chk(OFS_DATA_LOW, 32'h0000_005e, "user id low");
		rd_chk(OFS_DATA_HIGH, 32'h0000_0003, "user id high");
	endtask : t_config

	// latch-only load, row program, then row erase
	task automatic t_flash();
		set_addr(15'h0012);
		apb(1'b1, OFS_DATA_LOW, 32'h0000_00a5);
		apb(1'b1, OFS_DATA_HIGH, 32'h0000_0001);
		apb(1'b1, OFS_CONTROL, 32'h0000_00a4);
		unlock(8'ha6);
		wait_idle();
		rd_chk(OFS_CONTROL, 32'h0000_00a4, "latch load ends");
		chk("no done for latch", {31'h0, nv_done_flag}, 32'h0);
		apb(1'b1, OFS_CONTROL, 32'h0000_0084);
		unlock(8'h86);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("stall status", {31'h0, last_rdata[STS_STALL]}, 32'h1);
		chk("busy status", {31'h0, last_rdata[STS_BUSY]}, 32'h1);
		chk("stall pin", {31'h0, cpu_stall}, 32'h1);
		wait_idle();
		chk("stall released", {31'h0, cpu_stall}, 32'h0);
		chk("program done", {31'h0, nv_done_flag}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h1);
		apb(1'b1, OFS_DATA_LOW, 32'h0);
		apb(1'b1, OFS_DATA_HIGH, 32'h0);
		apb(1'b1, OFS_CONTROL, 32'h0000_0085);
		rd_chk(OFS_DATA_LOW, 32'h0000_00a5, "flash low");
		rd_chk(OFS_DATA_HIGH, 32'h0000_0001, "flash high");
		apb(1'b1, OFS_CONTROL, 32'h0000_0094);
		unlock(8'h96);
		wait_idle();
		chk("erase bit cleared", last_rdata, 32'h0000_0084);
		apb(1'b1, OFS_STATUS, 32'h1);
		apb(1'b1, OFS_CONTROL, 32'h0000_0085);
		rd_chk(OFS_DATA_LOW, {24'h0, ERASED_WORD[7:0]}, "erased low");
		rd_chk(OFS_DATA_HIGH, {26'h0, ERASED_WORD[13:8]}, "erased high");
	endtask : t_flash

	// main sequence
	initial
	begin
		fail_count = 0;
		n_checks   = 0;
		cycles     = 0;
		presetn    = 1'b0;
		ce         = 1'b1;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0;
		pstrb      = 4'hf;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_locked();
		t_gate();
		ee_round(8'h3c, 8'h04);
		ee_round(8'hc3, 8'h34);
		t_config();
		t_flash();
		conclude();
	end
endmodule : tb
`default_nettype wire
